// >>> rtv_regs.sv
`timescale 1ns/100ps
module rtv_regs
	import rtv_pkg::*;
#(
	parameter int unsigned TICK_CYC = TICK_CYCLES
) (
	input  wire logic              CORE_CLK_I,
	input  wire logic              RESET_I,
	input  wire logic [ADDR_W-1:0] S_AXI_AWADDR_I,
	input  wire logic              S_AXI_AWVALID_I,
	output logic                   S_AXI_AWREADY_O,
	input  wire logic [31:0]       S_AXI_WDATA_I,
	input  wire logic [3:0]        S_AXI_WSTRB_I,
	input  wire logic              S_AXI_WVALID_I,
	output logic                   S_AXI_WREADY_O,
	output logic [1:0]             S_AXI_BRESP_O,
	output logic                   S_AXI_BVALID_O,
	input  wire logic              S_AXI_BREADY_I,
	input  wire logic [ADDR_W-1:0] S_AXI_ARADDR_I,
	input  wire logic              S_AXI_ARVALID_I,
	output logic                   S_AXI_ARREADY_O,
	output logic [31:0]            S_AXI_RDATA_O,
	output logic [1:0]             S_AXI_RRESP_O,
	output logic                   S_AXI_RVALID_O,
	input  wire logic              S_AXI_RREADY_I
);
	logic [ADDR_W-1:0] aw_addr_r;
	logic [15:0]       w_data_r;
	logic [1:0]        w_strb_r;
	logic              aw_hold_r, w_hold_r;
	logic              aw_take, w_take, ar_take, do_write;
	logic              aw_hold_nxt, w_hold_nxt, bvalid_nxt, rvalid_nxt;
	rtv_sel_t          wsel, rsel, rsel_r;
	logic [1:0]        ctrl_r;
	logic [15:0]       alarm_r;
	logic [15:0]       wh_val, ms_val;
	logic [15:0]       wh_new, ms_new, alm_new;
	logic              unlock, tick, ld_wh, ld_ms, ld_alm;
	logic [15:0]       rd_word;

	// Byte-lane merge of the held write data over a current value
	function automatic logic [15:0] merge(input logic [15:0] cur,
	                                      input logic [15:0] nw,
	                                      input logic [1:0]  st);
		merge[7:0]  = st[0] ? nw[7:0]  : cur[7:0];
		merge[15:8] = st[1] ? nw[15:8] : cur[15:8];
	endfunction

	// Per-digit choice: a value above the digit's limit keeps the old one
	function automatic logic [3:0] pick(input logic [3:0] cur, input logic [3:0] nw,
	                                    input logic [3:0] lim);
		return (nw <= lim) ? nw : cur;
	endfunction

	assign unlock   = ctrl_r[CTRL_UNLOCK];
	assign aw_take  = S_AXI_AWVALID_I && S_AXI_AWREADY_O;
	assign w_take   = S_AXI_WVALID_I && S_AXI_WREADY_O;
	assign ar_take  = S_AXI_ARVALID_I && S_AXI_ARREADY_O;
	assign do_write = aw_hold_r && w_hold_r && !S_AXI_BVALID_O;
	assign wsel     = sel_decode(aw_addr_r);
	assign rsel     = sel_decode(S_AXI_ARADDR_I);

	assign aw_hold_nxt = (aw_hold_r || aw_take) && !do_write;
	assign w_hold_nxt  = (w_hold_r || w_take) && !do_write;
	assign bvalid_nxt  = do_write || (S_AXI_BVALID_O && !S_AXI_BREADY_I);
	assign rvalid_nxt  = ar_take || (S_AXI_RVALID_O && !S_AXI_RREADY_I);

	always_comb begin
		wh_new  = merge(wh_val, w_data_r, w_strb_r);
		ms_new  = merge(ms_val, w_data_r, w_strb_r);
		alm_new = merge(alarm_r, w_data_r, w_strb_r);
		wh_new[WD_HI:WD_LO] = 3'(pick({1'b0, wh_val[WD_HI:WD_LO]},
		                           {1'b0, wh_new[WD_HI:WD_LO]}, {1'b0, WEEKDAY_CODE_MAX}));
		wh_new[HT_HI:HT_LO] = 2'(pick({2'b0, wh_val[HT_HI:HT_LO]},
		                           {2'b0, wh_new[HT_HI:HT_LO]}, {2'b0, HT_MAX}));
		wh_new[U_HI:U_LO]   = pick(wh_val[U_HI:U_LO], wh_new[U_HI:U_LO], DIG_MAX);
		ms_new[MT_HI:MT_LO] = 3'(pick({1'b0, ms_val[MT_HI:MT_LO]},
		                           {1'b0, ms_new[MT_HI:MT_LO]}, {1'b0, TEN_MAX}));
		ms_new[MU_HI:MU_LO] = pick(ms_val[MU_HI:MU_LO], ms_new[MU_HI:MU_LO], DIG_MAX);
		ms_new[ST_HI:ST_LO] = 3'(pick({1'b0, ms_val[ST_HI:ST_LO]},
		                           {1'b0, ms_new[ST_HI:ST_LO]}, {1'b0, TEN_MAX}));
		ms_new[U_HI:U_LO]   = pick(ms_val[U_HI:U_LO], ms_new[U_HI:U_LO], DIG_MAX);
		alm_new[MU_HI:MU_LO] = pick(alarm_r[MU_HI:MU_LO], alm_new[MU_HI:MU_LO], DIG_MAX);
		alm_new[HT_HI:HT_LO] = 2'(pick({2'b0, alarm_r[HT_HI:HT_LO]},
		                            {2'b0, alm_new[HT_HI:HT_LO]}, {2'b0, DT_MAX}));
		alm_new[U_HI:U_LO]  = pick(alarm_r[U_HI:U_LO], alm_new[U_HI:U_LO], DIG_MAX);
		alm_new = alm_new & ALM_USED;
	end

	// Weekday/hour and alarm loads need the unlock bit; minutes/seconds do not
	assign ld_wh  = do_write && wsel == SEL_WH && unlock;
	assign ld_alm = do_write && wsel == SEL_ALM && unlock;
	assign ld_ms  = do_write && wsel == SEL_MS;

	always_comb begin
		rd_word = '0;
		case (rsel)
			SEL_CTRL: rd_word = {14'h0000, ctrl_r};
			SEL_WH:   rd_word = wh_val & WH_USED;
			SEL_MS:   rd_word = ms_val & MS_USED;
			SEL_ALM:  rd_word = alarm_r;
			default:  rd_word = '0;
		endcase
	end

	// Write address and data channels, taken in either order
	always_ff @(posedge CORE_CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			aw_hold_r <= 1'b0;
			aw_addr_r <= '0;
		end else begin
			aw_hold_r <= aw_hold_nxt;
			if (aw_take) begin
				aw_addr_r <= S_AXI_AWADDR_I;
			end
		end
	end

	always_ff @(posedge CORE_CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			w_hold_r <= 1'b0;
			w_data_r <= '0;
			w_strb_r <= '0;
		end else begin
			w_hold_r <= w_hold_nxt;
			if (w_take) begin
				w_data_r <= S_AXI_WDATA_I[15:0];
				w_strb_r <= S_AXI_WSTRB_I[1:0];
			end
		end
	end

	always_ff @(posedge CORE_CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			S_AXI_AWREADY_O <= 1'b0;
			S_AXI_WREADY_O  <= 1'b0;
			S_AXI_BVALID_O  <= 1'b0;
			S_AXI_BRESP_O   <= RESP_OKAY;
		end else begin
			S_AXI_AWREADY_O <= !aw_hold_nxt && !bvalid_nxt;
			S_AXI_WREADY_O  <= !w_hold_nxt && !bvalid_nxt;
			S_AXI_BVALID_O  <= bvalid_nxt;
			if (do_write) begin
				S_AXI_BRESP_O <= (wsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
			end
		end
	end

	// Read channel: one read at a time, data captured with the address
	always_ff @(posedge CORE_CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			S_AXI_ARREADY_O <= 1'b0;
			S_AXI_RVALID_O  <= 1'b0;
			S_AXI_RDATA_O   <= '0;
			S_AXI_RRESP_O   <= RESP_OKAY;
			rsel_r          <= SEL_NONE;
		end else begin
			S_AXI_ARREADY_O <= !rvalid_nxt;
			S_AXI_RVALID_O  <= rvalid_nxt;
			if (ar_take) begin
				S_AXI_RDATA_O <= {16'h0000, rd_word};
				S_AXI_RRESP_O <= (rsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
				rsel_r        <= rsel;
			end
		end
	end

	always_ff @(posedge CORE_CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			ctrl_r <= CTRL_RESET;
		end else if (do_write && wsel == SEL_CTRL && w_strb_r[0]) begin
			ctrl_r <= w_data_r[1:0];
		end
	end

	always_ff @(posedge CORE_CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			alarm_r <= ALM_RESET;
		end else if (ld_alm) begin
			alarm_r <= alm_new;
		end
	end

	rtv_tick_gen #(
		.CYCLES (TICK_CYC)
	) u_tick (
		.clk_i  (CORE_CLK_I),
		.rst_i  (RESET_I),
		.run_i  (ctrl_r[CTRL_RUN]),
		.tick_o (tick)
	);

	rtv_time_count u_time (
		.clk_i   (CORE_CLK_I),
		.rst_i   (RESET_I),
		.tick_i  (tick),
		.ld_wh_i (ld_wh),
		.wh_i    (wh_new),
		.ld_ms_i (ld_ms),
		.ms_i    (ms_new),
		.wh_o    (wh_val),
		.ms_o    (ms_val)
	);

	a_weekday_range: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
		ld_wh && w_strb_r[1] && w_data_r[WD_HI:WD_LO] > WEEKDAY_CODE_MAX
		|=> wh_val[WD_HI:WD_LO] == $past(wh_val[WD_HI:WD_LO]))
		else $error("Weekday accepted a value above six");

	a_hour_tens: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
		ld_wh && w_strb_r[0] && w_data_r[HT_HI:HT_LO] <= HT_MAX
		|=> wh_val[HT_HI:HT_LO] == $past(w_data_r[HT_HI:HT_LO]))
		else $error("Hour tens digit did not take a legal write");

	a_hour_units: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
		wh_val[U_HI:U_LO] <= DIG_MAX)
		else $error("Hour units digit above nine");

	a_minute_tens: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
		ld_ms && w_strb_r[1] && w_data_r[MT_HI:MT_LO] > TEN_MAX
		|=> ms_val[MT_HI:MT_LO] == $past(ms_val[MT_HI:MT_LO]))
		else $error("Minute tens digit accepted a value above five");

	a_minute_units: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
		ms_val[MU_HI:MU_LO] <= DIG_MAX)
		else $error("Minute units digit above nine");

	a_second_tens: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
		ld_ms && w_strb_r[0] && w_data_r[ST_HI:ST_LO] <= TEN_MAX
		|=> ms_val[ST_HI:ST_LO] == $past(w_data_r[ST_HI:ST_LO]))
		else $error("Second tens digit did not take a legal write");

	a_second_units: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
		ms_val[U_HI:U_LO] <= DIG_MAX)
		else $error("Second units digit above nine");

	a_alarm_fields: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
		alarm_r[HT_HI:HT_LO] <= DT_MAX && alarm_r[U_HI:U_LO] <= DIG_MAX &&
		alarm_r[MU_HI:MU_LO] <= DIG_MAX && (alarm_r & ~ALM_USED) == '0)
		else $error("Alarm month/date holds an illegal digit");

	a_locked_write: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
		do_write && !unlock && (wsel == SEL_ALM || wsel == SEL_WH)
		|=> $stable(alarm_r) && ($stable(wh_val) || $past(tick)))
		else $error("Locked write changed weekday/hour or alarm");

	a_unused_zero: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
		S_AXI_RVALID_O && rsel_r == SEL_WH |-> (S_AXI_RDATA_O[15:0] & ~WH_USED) == '0)
		else $error("Unused weekday/hour bits read nonzero");

	a_weekday_load: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
		ld_wh && w_strb_r[1] && w_data_r[WD_HI:WD_LO] <= WEEKDAY_CODE_MAX
		|=> wh_val[WD_HI:WD_LO] == $past(w_data_r[WD_HI:WD_LO]))
		else $error("Weekday did not take a legal write");

	a_weekday_bound: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
		wh_val[WD_HI:WD_LO] <= WEEKDAY_CODE_MAX)
		else $error("Weekday above six");

	a_hour_tens_bound: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
		wh_val[HT_HI:HT_LO] <= HT_MAX)
		else $error("Hour tens digit above two");

	a_hour_units_load: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
		ld_wh && w_strb_r[0] && w_data_r[U_HI:U_LO] > DIG_MAX
		|=> wh_val[U_HI:U_LO] == $past(wh_val[U_HI:U_LO]))
		else $error("Hour units digit accepted a value above nine");

	a_minute_tens_load: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
		ld_ms && w_strb_r[1] && w_data_r[MT_HI:MT_LO] <= TEN_MAX
		|=> ms_val[MT_HI:MT_LO] == $past(w_data_r[MT_HI:MT_LO]))
		else $error("Minute tens digit did not take a legal write");

	a_minute_units_load: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
		ld_ms && w_strb_r[1] && w_data_r[MU_HI:MU_LO] > DIG_MAX
		|=> ms_val[MU_HI:MU_LO] == $past(ms_val[MU_HI:MU_LO]))
		else $error("Minute units digit accepted a value above nine");

	a_second_tens_bound: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
		ms_val[ST_HI:ST_LO] <= TEN_MAX)
		else $error("Second tens digit above five");

	a_second_units_load: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
		ld_ms && w_strb_r[0] && w_data_r[U_HI:U_LO] > DIG_MAX
		|=> ms_val[U_HI:U_LO] == $past(ms_val[U_HI:U_LO]))
		else $error("Second units digit accepted a value above nine");

	a_alarm_load: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
		ld_alm && w_strb_r == 2'h3 && w_data_r[MU_HI:MU_LO] <= DIG_MAX &&
		w_data_r[HT_HI:HT_LO] <= DT_MAX && w_data_r[U_HI:U_LO] <= DIG_MAX
		|=> alarm_r == ($past(w_data_r) & ALM_USED))
		else $error("Alarm month/date did not take a legal write");

	a_unused_ms: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
		S_AXI_RVALID_O && rsel_r == SEL_MS |-> (S_AXI_RDATA_O[15:0] & ~MS_USED) == '0)
		else $error("Unused minute/second bits read nonzero");

	a_upper_zero: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
		S_AXI_RVALID_O |-> S_AXI_RDATA_O[31:16] == '0)
		else $error("Upper read data half nonzero");

	a_write_slverr: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
		do_write && wsel == SEL_NONE |=> S_AXI_BVALID_O && S_AXI_BRESP_O == RESP_SLVERR)
		else $error("Unmapped write not answered with an error");

	a_read_slverr: assert property (@(posedge CORE_CLK_I) disable iff (RESET_I)
		ar_take && rsel == SEL_NONE |=> S_AXI_RVALID_O && S_AXI_RRESP_O == RESP_SLVERR)
		else $error("Unmapped read not answered with an error");
endmodule

// >>> rtv_pkg.sv
package rtv_pkg;
	localparam int          ADDR_W        = 4;
	localparam logic [3:0]  ADDR_CTRL     = 4'h0;
	localparam logic [3:0]  ADDR_WH       = 4'h4;
	localparam logic [3:0]  ADDR_MS       = 4'h8;
	localparam logic [3:0]  ADDR_ALM      = 4'hc;
	localparam int          CTRL_UNLOCK   = 0;
	localparam int          CTRL_RUN      = 1;
	localparam logic [1:0]  CTRL_RESET    = 2'h2;
	localparam logic [15:0] WH_RESET      = 16'h0000;
	localparam logic [15:0] MS_RESET      = 16'h0000;
	localparam logic [15:0] ALM_RESET     = 16'h0000;
	localparam logic [1:0]  RESP_OKAY     = 2'h0;
	localparam logic [1:0]  RESP_SLVERR   = 2'h2;
	localparam int          WD_HI         = 10;
	localparam int          WD_LO         = 8;
	localparam int          HT_HI         = 5;
	localparam int          HT_LO         = 4;
	localparam int          U_HI          = 3;
	localparam int          U_LO          = 0;
	localparam int          MT_HI         = 14;
	localparam int          MT_LO         = 12;
	localparam int          MU_HI         = 11;
	localparam int          MU_LO         = 8;
	localparam int          ST_HI         = 6;
	localparam int          ST_LO         = 4;
	localparam int          AMT_BIT       = 12;
	localparam logic [2:0]  WEEKDAY_CODE_MAX      = 3'h6;
	localparam logic [1:0]  HT_MAX        = 2'h2;
	localparam logic [3:0]  DIG_MAX       = 4'h9;
	localparam logic [2:0]  TEN_MAX       = 3'h5;
	localparam logic [1:0]  DT_MAX        = 2'h3;
	localparam logic [3:0]  HU_LAST       = 4'h3;
	localparam logic [15:0] WH_USED       = 16'h073f;
	localparam logic [15:0] MS_USED       = 16'h7f7f;
	localparam logic [15:0] ALM_USED      = 16'h1f3f;
	localparam logic [15:0] MS_LAST       = 16'h5959;
	localparam logic [6:0]  SEC_LAST      = 7'h59;
	localparam logic [5:0]  HR_LAST       = 6'h23;
	localparam longint      CLK_HZ        = 100000000;
	localparam longint      TICK_MS       = 1000;
	localparam longint      MS_PER_S      = 1000;
	localparam int unsigned TICK_CYCLES   = int'(CLK_HZ * TICK_MS / MS_PER_S);
	localparam int          CNT_W         = 27;

	typedef enum {SEL_CTRL, SEL_WH, SEL_MS, SEL_ALM, SEL_NONE} rtv_sel_t;

	function automatic rtv_sel_t sel_decode(input logic [ADDR_W-1:0] a);
		if (a == ADDR_CTRL) begin
			return SEL_CTRL;
		end else if (a == ADDR_WH) begin
			return SEL_WH;
		end else if (a == ADDR_MS) begin
			return SEL_MS;
		end else if (a == ADDR_ALM) begin
			return SEL_ALM;
		end else begin
			return SEL_NONE;
		end
	endfunction
endpackage

// >>> rtv_tick_gen.sv
`timescale 1ns/100ps
module rtv_tick_gen
	import rtv_pkg::*;
#(
	parameter int unsigned CYCLES = TICK_CYCLES
) (
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic run_i,
	output logic      tick_o
);
	localparam logic [CNT_W-1:0] LAST = CNT_W'(CYCLES - 1);

	logic [CNT_W-1:0] cnt_r;

	// Divides the core clock down to one pulse per second
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			cnt_r <= '0;
		end else if (!run_i || cnt_r == LAST) begin
			cnt_r <= '0;
		end else begin
			cnt_r <= cnt_r + 1'b1;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			tick_o <= 1'b0;
		end else begin
			tick_o <= run_i && cnt_r == LAST;
		end
	end
endmodule

// >>> rtv_time_count.sv
`timescale 1ns/100ps
module rtv_time_count
	import rtv_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        tick_i,
	input  wire logic        ld_wh_i,
	input  wire logic [15:0] wh_i,
	input  wire logic        ld_ms_i,
	input  wire logic [15:0] ms_i,
	output logic      [15:0] wh_o,
	output logic      [15:0] ms_o
);
	logic adv;
	logic su_end, st_end, mu_end, mt_end, hr_end;

	// A software load takes the cycle; a tick landing on it is dropped
	assign adv    = tick_i && !ld_wh_i && !ld_ms_i;
	assign su_end = ms_o[U_HI:U_LO] == DIG_MAX;
	assign st_end = ms_o[ST_HI:ST_LO] == TEN_MAX;
	assign mu_end = ms_o[MU_HI:MU_LO] == DIG_MAX;
	assign mt_end = ms_o[MT_HI:MT_LO] == TEN_MAX;
	assign hr_end = wh_o[HT_HI:HT_LO] == HT_MAX && wh_o[U_HI:U_LO] >= HU_LAST;

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			ms_o <= MS_RESET;
		end else if (ld_ms_i) begin
			ms_o <= ms_i & MS_USED;
		end else if (adv) begin
			ms_o[U_HI:U_LO] <= su_end ? '0 : ms_o[U_HI:U_LO] + 1'b1;
			if (su_end) begin
				ms_o[ST_HI:ST_LO] <= st_end ? '0 : ms_o[ST_HI:ST_LO] + 1'b1;
				if (st_end) begin
					ms_o[MU_HI:MU_LO] <= mu_end ? '0 : ms_o[MU_HI:MU_LO] + 1'b1;
					if (mu_end) begin
						ms_o[MT_HI:MT_LO] <= mt_end ? '0 : ms_o[MT_HI:MT_LO] + 1'b1;
					end
				end
			end
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			wh_o <= WH_RESET;
		end else if (ld_wh_i) begin
			wh_o <= wh_i & WH_USED;
		end else if (adv && ms_o == MS_LAST) begin
			if (hr_end) begin
				wh_o[HT_HI:HT_LO] <= '0;
				wh_o[U_HI:U_LO]   <= '0;
				wh_o[WD_HI:WD_LO] <= wh_o[WD_HI:WD_LO] >= WEEKDAY_CODE_MAX ? '0
				                     : wh_o[WD_HI:WD_LO] + 1'b1;
			end else if (wh_o[U_HI:U_LO] == DIG_MAX) begin
				wh_o[U_HI:U_LO]   <= '0;
				wh_o[HT_HI:HT_LO] <= wh_o[HT_HI:HT_LO] + 1'b1;
			end else begin
				wh_o[U_HI:U_LO] <= wh_o[U_HI:U_LO] + 1'b1;
			end
		end
	end

	a_second_roll: assert property (@(posedge clk_i) disable iff (rst_i)
		adv && ms_o[ST_HI:U_LO] == SEC_LAST |=> ms_o[ST_HI:U_LO] == '0)
		else $error("Seconds did not roll from 59 to 00");

	a_day_roll: assert property (@(posedge clk_i) disable iff (rst_i)
		adv && ms_o == MS_LAST && wh_o[HT_HI:U_LO] == HR_LAST
		|=> wh_o[HT_HI:U_LO] == '0 && ms_o == '0 &&
		    wh_o[WD_HI:WD_LO] == ($past(wh_o[WD_HI:WD_LO]) == WEEKDAY_CODE_MAX ? 3'h0
		                          : $past(wh_o[WD_HI:WD_LO]) + 3'h1))
		else $error("Midnight did not clear hours and advance weekday");
endmodule

// >>> rtv_time_alarm_value_regs_tb.sv
`timescale 1ns/100ps
module rtv_time_alarm_value_regs_tb
	import rtv_pkg::*;
();
	logic              core_clk;
	logic              reset;
	logic [ADDR_W-1:0] aw_addr;
	logic              aw_valid;
	logic [31:0]       w_data;
	logic [3:0]        w_strb;
	logic              w_valid;
	logic              b_ready;
	logic [ADDR_W-1:0] ar_addr;
	logic              ar_valid;
	logic              r_ready;
	wire logic         aw_ready;
	wire logic         w_ready;
	wire logic [1:0]   b_resp;
	wire logic         b_valid;
	wire logic         ar_ready;
	wire logic [31:0]  r_data;
	wire logic [1:0]   r_resp;
	wire logic         r_valid;
	int                fails;
	int                n_tests;

	rtv_regs #(.TICK_CYC(10)) rtv_regs_i (
		.CORE_CLK_I      (core_clk),
		.RESET_I         (reset),
		.S_AXI_AWADDR_I  (aw_addr),
		.S_AXI_AWVALID_I (aw_valid),
		.S_AXI_AWREADY_O (aw_ready),
		.S_AXI_WDATA_I   (w_data),
		.S_AXI_WSTRB_I   (w_strb),
		.S_AXI_WVALID_I  (w_valid),
		.S_AXI_WREADY_O  (w_ready),
		.S_AXI_BRESP_O   (b_resp),
		.S_AXI_BVALID_O  (b_valid),
		.S_AXI_BREADY_I  (b_ready),
		.S_AXI_ARADDR_I  (ar_addr),
		.S_AXI_ARVALID_I (ar_valid),
		.S_AXI_ARREADY_O (ar_ready),
		.S_AXI_RDATA_O   (r_data),
		.S_AXI_RRESP_O   (r_resp),
		.S_AXI_RVALID_O  (r_valid),
		.S_AXI_RREADY_I  (r_ready)
	);

	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	task automatic report_and_stop();
		$display("Comparisons %0d, mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			fails++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic hang();
		fails++;
		$display("Error at %0t: bus answer never came", $time);
		report_and_stop();
	endtask

	// AW and W hold valid until their ready, and B holds ready until valid, is seen high at a rising edge
	task automatic axi_wr(input logic [3:0] a, input logic [15:0] d, input logic [1:0] er);
		logic       got;
		logic [1:0] resp;
		int         k;
		got = 1'b0;
		resp = 2'h3;
		@(posedge core_clk);
		aw_addr <= a;
		w_data <= {16'h0000, d};
		w_strb <= 4'h3;
		aw_valid <= 1'b1;
		w_valid <= 1'b1;
		b_ready <= 1'b1;
		for (k = 0; k < 100 && !got; k++) begin
			@(posedge core_clk);
			if (aw_valid && aw_ready === 1'b1) begin
				aw_valid <= 1'b0;
			end
			if (w_valid && w_ready === 1'b1) begin
				w_valid <= 1'b0;
			end
			if (b_ready && b_valid === 1'b1) begin
				got = 1'b1;
				resp = b_resp;
				b_ready <= 1'b0;
			end
		end
		if (!got) begin
			hang();
		end
		check({30'h0, resp}, {30'h0, er});
	endtask

	task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
		logic got;
		int   k;
		got = 1'b0;
		d = 32'h0;
		r = 2'h3;
		@(posedge core_clk);
		ar_addr <= a;
		ar_valid <= 1'b1;
		r_ready <= 1'b1;
		for (k = 0; k < 100 && !got; k++) begin
			@(posedge core_clk);
			if (ar_valid && ar_ready === 1'b1) begin
				ar_valid <= 1'b0;
			end
			if (r_ready && r_valid === 1'b1) begin
				got = 1'b1;
				d = r_data;
				r = r_resp;
				r_ready <= 1'b0;
			end
		end
		if (!got) begin
			hang();
		end
	endtask

	task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp);
		logic [31:0] d;
		logic [1:0]  r;
		axi_rd(a, d, r);
		check(d, {16'h0000, exp});
		check({30'h0, r}, {30'h0, RESP_OKAY});
	endtask

	task automatic t_reset_values();
		rd_chk(ADDR_CTRL, {14'h0, CTRL_RESET});
		rd_chk(ADDR_WH, WH_RESET);
		rd_chk(ADDR_ALM, ALM_RESET);
	endtask

	task automatic t_locked();
		axi_wr(ADDR_CTRL, 16'h0000, RESP_OKAY);
		axi_wr(ADDR_WH, 16'h0312, RESP_OKAY);
		axi_wr(ADDR_ALM, 16'h0415, RESP_OKAY);
		rd_chk(ADDR_WH, WH_RESET);
		rd_chk(ADDR_ALM, ALM_RESET);
		axi_wr(ADDR_MS, 16'h1234, RESP_OKAY);
		rd_chk(ADDR_MS, 16'h1234);
	endtask

	task automatic t_unmapped();
		logic [31:0] d;
		logic [1:0]  r;
		axi_wr(4'h2, 16'h0003, RESP_SLVERR);
		axi_rd(4'h2, d, r);
		check({30'h0, r}, {30'h0, RESP_SLVERR});
		rd_chk(ADDR_CTRL, 16'h0000);
	endtask

	task automatic t_fields();
		axi_wr(ADDR_CTRL, 16'h0001, RESP_OKAY);
		rd_chk(ADDR_CTRL, 16'h0001);
		axi_wr(ADDR_WH, 16'h0623, RESP_OKAY);
		rd_chk(ADDR_WH, 16'h0623);
		axi_wr(ADDR_WH, 16'hffff, RESP_OKAY);
		rd_chk(ADDR_WH, 16'h0623);
		axi_wr(ADDR_WH, 16'h0519, RESP_OKAY);
		rd_chk(ADDR_WH, 16'h0519);
		axi_wr(ADDR_MS, 16'h5959, RESP_OKAY);
		rd_chk(ADDR_MS, 16'h5959);
		axi_wr(ADDR_MS, 16'hffff, RESP_OKAY);
		rd_chk(ADDR_MS, 16'h5959);
		axi_wr(ADDR_MS, 16'h3847, RESP_OKAY);
		rd_chk(ADDR_MS, 16'h3847);
		axi_wr(ADDR_ALM, 16'h1231, RESP_OKAY);
		rd_chk(ADDR_ALM, 16'h1231);
		axi_wr(ADDR_ALM, 16'h0905, RESP_OKAY);
		axi_wr(ADDR_ALM, 16'hffff, RESP_OKAY);
		rd_chk(ADDR_ALM, 16'h1935);
	endtask

	// Counting stopped while loading, then run until the seconds move once
	task automatic t_roll(input logic [15:0] wh0, input logic [15:0] ms0,
	                      input logic [15:0] wh_exp, input logic [15:0] ms_exp);
		logic [31:0] d;
		logic [1:0]  r;
		int          k;
		axi_wr(ADDR_CTRL, 16'h0001, RESP_OKAY);
		axi_wr(ADDR_WH, wh0, RESP_OKAY);
		axi_wr(ADDR_MS, ms0, RESP_OKAY);
		axi_wr(ADDR_CTRL, 16'h0003, RESP_OKAY);
		d = {16'h0000, ms0};
		for (k = 0; k < 50 && d === {16'h0000, ms0}; k++) begin
			axi_rd(ADDR_MS, d, r);
		end
		check(d, {16'h0000, ms_exp});
		axi_rd(ADDR_WH, d, r);
		check(d, {16'h0000, wh_exp});
		axi_wr(ADDR_CTRL, 16'h0001, RESP_OKAY);
	endtask

	initial begin
		fails = 0;
		n_tests = 0;
		reset = 1'b1;
		aw_addr = '0;
		aw_valid = 1'b0;
		w_data = 32'h0;
		w_strb = 4'h0;
		w_valid = 1'b0;
		b_ready = 1'b0;
		ar_addr = '0;
		ar_valid = 1'b0;
		r_ready = 1'b0;
		repeat (16) @(posedge core_clk);
		reset <= 1'b0;
		t_reset_values();
		t_locked();
		t_unmapped();
		t_fields();
		t_roll(16'h0623, 16'h5958, 16'h0623, 16'h5959);
		t_roll(16'h0623, 16'h5959, 16'h0000, 16'h0000);
		t_roll(16'h0219, 16'h5959, 16'h0220, 16'h0000);
		t_roll(16'h0109, 16'h0959, 16'h0109, 16'h1000);
		t_roll(16'h0309, 16'h1009, 16'h0309, 16'h1010);
		report_and_stop();
	end
endmodule
